// >>> rtdseq_map.svh
// Purpose: Offsets, fields, reset values and timing counts of the RTD sequencer
// Assumes: 250 MHz core clock, registers reached over APB
// Notes: Macros only; the package holds the types
`ifndef RTDSEQ_MAP_SVH
`define RTDSEQ_MAP_SVH

`define RTDSEQ_CLK_MHZ 250
`define RTDSEQ_OFF_CTRL 8'h00
`define RTDSEQ_OFF_CMD 8'h04
`define RTDSEQ_OFF_STAT 8'h08
`define RTDSEQ_OFF_PORT0 8'h0c
`define RTDSEQ_OFF_TRIM 8'h1c
`define RTDSEQ_ORDER_LSB 0
`define RTDSEQ_DUMMY_LSB 2
`define RTDSEQ_SPACE_LSB 5
`define RTDSEQ_LIMIT_LSB 7
`define RTDSEQ_PERIOD_LSB 10
`define RTDSEQ_INTEN_BIT 14
`define RTDSEQ_CTRL_RESET 15'h1b8b
`define RTDSEQ_OP_TEMP 8'h03
`define RTDSEQ_OP_CAL 8'h0e
`define RTDSEQ_CHARGE_NS 1000
`define RTDSEQ_SHORT_NS 8000
`define RTDSEQ_OPEN_NS 2000
`define RTDSEQ_SPACE_BASE_US 128
`define RTDSEQ_LIMIT_BASE_US 256
`define RTDSEQ_REF_NS 250
`define RTDSEQ_CHARGE_CYC ((`RTDSEQ_CHARGE_NS * `RTDSEQ_CLK_MHZ + 999) / 1000)
`define RTDSEQ_SHORT_CYC ((`RTDSEQ_SHORT_NS * `RTDSEQ_CLK_MHZ + 999) / 1000)
`define RTDSEQ_OPEN_CYC ((`RTDSEQ_OPEN_NS * `RTDSEQ_CLK_MHZ) / 1000)
`define RTDSEQ_TICK_FRAC ((65536 * 1000 / `RTDSEQ_CLK_MHZ + `RTDSEQ_REF_NS / 2) / `RTDSEQ_REF_NS)

`endif

// >>> rtdseq_pkg.sv
// Purpose: Types shared by the RTD sequencer
// Assumes: Nothing beyond the map header
// Notes: One-hot state codes
`default_nettype none
package rtdseq_pkg;
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_CHARGE = 9'h002,
        ST_DISCH = 9'h004,
        ST_SPACE = 9'h008,
        ST_COMMIT = 9'h010,
        ST_CARM = 9'h020,
        ST_CMEAS = 9'h040,
        ST_CDIV = 9'h080,
        ST_CDONE = 9'h100
    } rtdseq_state_t;
endpackage
`default_nettype wire

// >>> rtdseq_div_if.sv
// Purpose: Request and answer wires between sequencer and averaging divider
// Assumes: One clock domain
// Notes: start is a one-cycle pulse, done likewise
`default_nettype none
interface rtdseq_div_if;
    logic start;
    logic [31:0] dividend;
    logic [3:0] divisor;
    logic done;
    logic [31:0] quotient;
    modport client (output start, output dividend, output divisor, input done, input quotient);
    modport server (input start, input dividend, input divisor, output done, output quotient);
endinterface
`default_nettype wire

// >>> rtdseq_div.sv
// Purpose: Restoring divider averaging the calibration sum
// Assumes: Divisor nonzero, start only while idle
// Notes: One quotient bit per cycle keeps the area small; 32 cycles per divide
`default_nettype none
module rtdseq_div (
    input wire logic clk,
    input wire logic rst_n,
    rtdseq_div_if.server dv
);
    logic [31:0] quo_reg;
    logic [3:0] rem_reg;
    logic [5:0] cnt_reg;
    logic done_reg;
    logic [4:0] trial;

    assign trial = {rem_reg, quo_reg[31]};
    assign dv.quotient = quo_reg;
    assign dv.done = done_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            quo_reg <= 32'h0;
            rem_reg <= 4'h0;
            cnt_reg <= 6'h0;
            done_reg <= 1'b0;
        end
        else if (dv.start)
        begin
            quo_reg <= dv.dividend;
            rem_reg <= 4'h0;
            cnt_reg <= 6'h20;
            done_reg <= 1'b0;
        end
        else if (cnt_reg != 6'h0)
        begin
            if (trial >= {1'b0, dv.divisor})
            begin
                rem_reg <= 4'(trial - {1'b0, dv.divisor});
                quo_reg <= {quo_reg[30:0], 1'b1};
            end
            else
            begin
                rem_reg <= trial[3:0];
                quo_reg <= {quo_reg[30:0], 1'b0};
            end
            cnt_reg <= cnt_reg - 6'h1;
            done_reg <= (cnt_reg == 6'h1);
        end
        else
        begin
            done_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> rtdseq_top.sv
// Purpose: Temperature port sequencer, slow-clock calibration and interrupt flags
// Assumes: Comparator and slow clock inputs already synchronous to clk
// Notes: Times count in core cycles and convert to reference periods with 16-bit fraction
`default_nettype none
`include "rtdseq_map.svh"
module rtdseq_top #(
    parameter int SPACE_BASE_CYC = `RTDSEQ_SPACE_BASE_US * `RTDSEQ_CLK_MHZ,
    parameter int LIMIT_BASE_CYC = `RTDSEQ_LIMIT_BASE_US * `RTDSEQ_CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic compBelow,
    input wire logic slowClk,
    output logic capChargeOut,
    output logic capChargeOe,
    output logic emuSelect,
    output logic [1:0] portSel,
    output logic busy,
    output logic intN
);
    rtdseq_pkg::rtdseq_state_t state_reg;
    logic [14:0] ctrl_reg;
    logic [23:0] stepCnt_reg;
    logic [23:0] dischCnt_reg;
    logic [2:0] dummyLeft_reg;
    logic [1:0] portIdx_reg;
    logic realPass_reg;
    logic faultAll_reg;
    logic [31:0] stage_reg [4];
    logic [31:0] portRes_reg [4];
    logic [30:0] trim_reg;
    logic [3:0] calEdges_reg;
    logic [31:0] calAcc_reg;
    logic [23:0] calCnt_reg;
    logic slowQ_reg;
    logic thermalDone_reg;
    logic calDone_reg;
    logic timeout_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic emuSelect_reg;
    logic [1:0] portSel_reg;

    logic setup;
    logic access;
    logic mapped;
    logic cmdTemp;
    logic cmdCal;
    logic [2:0] statClr;
    logic slowRise;
    logic [1:0] orderSel;
    logic [1:0] lastIdx;
    logic [3:0] calPeriod;
    logic [23:0] spaceCyc;
    logic [23:0] limitCyc;
    logic [39:0] timeProd;
    logic [31:0] measTime;
    logic measShort;
    logic stepEnd;
    logic lastStep;
    logic setTemp;
    logic setCal;
    logic setTimeout;

    rtdseq_div_if divIf ();

    rtdseq_div u_div (
        .clk(clk),
        .rst_n(rst_n),
        .dv(divIf.server)
    );

    function automatic logic [1:0] portOf(input logic [1:0] sel, input logic [1:0] idx);
        case (sel)
            2'b00: portOf = {idx[0], 1'b0};
            2'b01: portOf = {idx[0], 1'b1};
            2'b10: portOf = {1'b0, idx[0]};
            default: portOf = idx;
        endcase
    endfunction

    assign orderSel = ctrl_reg[`RTDSEQ_ORDER_LSB +: 2];
    assign lastIdx = (orderSel == 2'b11) ? 2'h3 : 2'h1;
    assign calPeriod = ctrl_reg[`RTDSEQ_PERIOD_LSB +: 4];
    assign spaceCyc = 24'(SPACE_BASE_CYC) << ctrl_reg[`RTDSEQ_SPACE_LSB +: 2];
    assign limitCyc = 24'(LIMIT_BASE_CYC * (int'(ctrl_reg[`RTDSEQ_LIMIT_LSB +: 3]) + 1));

    // Bus: zero wait states, read data captured in the setup cycle
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `RTDSEQ_OFF_TRIM);
    assign cmdTemp = access && pwrite && !pslverr_reg && (paddr == `RTDSEQ_OFF_CMD)
        && (pwdata[7:0] == `RTDSEQ_OP_TEMP);
    assign cmdCal = access && pwrite && !pslverr_reg && (paddr == `RTDSEQ_OFF_CMD)
        && (pwdata[7:0] == `RTDSEQ_OP_CAL);
    // Only flags shown to the reader are cleared; later ones survive the read
    assign statClr = (access && !pwrite && paddr == `RTDSEQ_OFF_STAT) ? prdata_reg[2:0] : 3'h0;

    assign slowRise = slowClk && !slowQ_reg;
    assign timeProd = 40'(dischCnt_reg) * 40'(`RTDSEQ_TICK_FRAC);
    assign measTime = timeProd[31:0];
    assign measShort = dischCnt_reg < 24'(`RTDSEQ_SHORT_CYC);
    assign stepEnd = (state_reg == rtdseq_pkg::ST_SPACE) && (stepCnt_reg >= spaceCyc - 24'h1);
    assign lastStep = (dummyLeft_reg == 3'h0) && realPass_reg && (portIdx_reg == lastIdx);

    assign capChargeOe = (state_reg == rtdseq_pkg::ST_CHARGE);
    assign capChargeOut = capChargeOe;
    assign emuSelect = emuSelect_reg;
    assign portSel = portSel_reg;
    assign busy = (state_reg != rtdseq_pkg::ST_IDLE);
    // Active low; held off entirely while the enable bit is clear
    assign intN = !(ctrl_reg[`RTDSEQ_INTEN_BIT]
        && (thermalDone_reg || calDone_reg || timeout_reg));

    assign divIf.start = (state_reg == rtdseq_pkg::ST_CMEAS) && slowRise
        && (calEdges_reg + 4'h1 == calPeriod);
    // Closing edge's own cycle is added here, so N periods count exactly N spans
    assign divIf.dividend = calAcc_reg + 32'(`RTDSEQ_TICK_FRAC);
    assign divIf.divisor = calPeriod;

    assign setTemp = (state_reg == rtdseq_pkg::ST_COMMIT);
    assign setCal = (state_reg == rtdseq_pkg::ST_CDONE);
    assign setTimeout = ((state_reg == rtdseq_pkg::ST_DISCH) && !compBelow
        && (stepCnt_reg >= spaceCyc + 24'(`RTDSEQ_OPEN_CYC)) && realPass_reg
        && dummyLeft_reg == 3'h0)
        || ((state_reg == rtdseq_pkg::ST_CARM || state_reg == rtdseq_pkg::ST_CMEAS)
        && calCnt_reg >= limitCyc);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
            ctrl_reg <= `RTDSEQ_CTRL_RESET;
        end
        else
        begin
            if (setup)
            begin
                pslverr_reg <= !mapped;
                case (paddr)
                    `RTDSEQ_OFF_CTRL: prdata_reg <= {17'h0, ctrl_reg};
                    `RTDSEQ_OFF_STAT: prdata_reg <= {28'h0, busy, timeout_reg, calDone_reg,
                        thermalDone_reg};
                    `RTDSEQ_OFF_TRIM: prdata_reg <= {1'b0, trim_reg};
                    8'h0c, 8'h10, 8'h14, 8'h18: prdata_reg <= portRes_reg[2'(paddr[7:2] - 6'h3)];
                    default: prdata_reg <= 32'h0;
                endcase
            end
            if (access && pwrite && paddr == `RTDSEQ_OFF_CTRL)
            begin
                ctrl_reg <= pwdata[14:0];
            end
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            thermalDone_reg <= 1'b0;
            calDone_reg <= 1'b0;
            timeout_reg <= 1'b0;
        end
        else
        begin
            thermalDone_reg <= (thermalDone_reg && !statClr[0]) || setTemp;
            calDone_reg <= (calDone_reg && !statClr[1]) || setCal;
            timeout_reg <= (timeout_reg && !statClr[2]) || setTimeout;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            slowQ_reg <= 1'b0;
        end
        else
        begin
            slowQ_reg <= slowClk;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= rtdseq_pkg::ST_IDLE;
            stepCnt_reg <= 24'h0;
            dischCnt_reg <= 24'h0;
            dummyLeft_reg <= 3'h0;
            portIdx_reg <= 2'h0;
            realPass_reg <= 1'b0;
            faultAll_reg <= 1'b0;
            emuSelect_reg <= 1'b0;
            portSel_reg <= 2'h0;
            calEdges_reg <= 4'h0;
            calAcc_reg <= 32'h0;
            calCnt_reg <= 24'h0;
            trim_reg <= 31'h0;
            for (int i = 0; i < 4; i++)
            begin
                stage_reg[i] <= 32'h0;
                portRes_reg[i] <= 32'h0;
            end
        end
        else
        begin
            case (state_reg)
                rtdseq_pkg::ST_IDLE:
                begin
                    stepCnt_reg <= 24'h0;
                    calCnt_reg <= 24'h0;
                    calAcc_reg <= 32'h0;
                    calEdges_reg <= 4'h0;
                    if (cmdTemp)
                    begin
                        dummyLeft_reg <= ctrl_reg[`RTDSEQ_DUMMY_LSB +: 3];
                        emuSelect_reg <= (ctrl_reg[`RTDSEQ_DUMMY_LSB +: 3] != 3'h0);
                        portIdx_reg <= 2'h0;
                        portSel_reg <= portOf(orderSel, 2'h0);
                        realPass_reg <= 1'b0;
                        faultAll_reg <= 1'b0;
                        state_reg <= rtdseq_pkg::ST_CHARGE;
                    end
                    else if (cmdCal)
                    begin
                        // A zero period count cannot be averaged; the command ends at once with calDone set and trim kept
                        state_reg <= (calPeriod == 4'h0) ? rtdseq_pkg::ST_CDONE
                            : rtdseq_pkg::ST_CARM;
                    end
                end
                rtdseq_pkg::ST_CHARGE:
                begin
                    stepCnt_reg <= stepCnt_reg + 24'h1;
                    dischCnt_reg <= 24'h0;
                    if (stepCnt_reg == 24'(`RTDSEQ_CHARGE_CYC - 1))
                    begin
                        // Comparator still low after charging: capacitor path is broken
                        if (compBelow)
                        begin
                            faultAll_reg <= 1'b1;
                        end
                        state_reg <= rtdseq_pkg::ST_DISCH;
                    end
                end
                rtdseq_pkg::ST_DISCH:
                begin
                    stepCnt_reg <= stepCnt_reg + 24'h1;
                    dischCnt_reg <= dischCnt_reg + 24'h1;
                    if (compBelow || setTimeout
                        || stepCnt_reg >= spaceCyc + 24'(`RTDSEQ_OPEN_CYC))
                    begin
                        if (realPass_reg && dummyLeft_reg == 3'h0)
                        begin
                            if (!compBelow)
                            begin
                                stage_reg[portSel_reg] <= 32'hffffffff;
                            end
                            else if (measShort)
                            begin
                                stage_reg[portSel_reg] <= 32'h0;
                            end
                            else
                            begin
                                stage_reg[portSel_reg] <= measTime;
                            end
                        end
                        state_reg <= rtdseq_pkg::ST_SPACE;
                    end
                end
                rtdseq_pkg::ST_SPACE:
                begin
                    stepCnt_reg <= stepCnt_reg + 24'h1;
                    if (stepEnd)
                    begin
                        stepCnt_reg <= 24'h0;
                        state_reg <= lastStep ? rtdseq_pkg::ST_COMMIT : rtdseq_pkg::ST_CHARGE;
                        if (dummyLeft_reg != 3'h0)
                        begin
                            dummyLeft_reg <= dummyLeft_reg - 3'h1;
                            emuSelect_reg <= (dummyLeft_reg != 3'h1);
                        end
                        else if (!realPass_reg)
                        begin
                            realPass_reg <= 1'b1;
                        end
                        else if (!lastStep)
                        begin
                            realPass_reg <= 1'b0;
                            portIdx_reg <= portIdx_reg + 2'h1;
                            portSel_reg <= portOf(orderSel, portIdx_reg + 2'h1);
                        end
                    end
                end
                rtdseq_pkg::ST_COMMIT:
                begin
                    // Unselected ports keep their previous results unless a charge fault sets all four to all ones
                    for (int i = 0; i < 4; i++)
                    begin
                        if (faultAll_reg)
                        begin
                            portRes_reg[i] <= 32'hffffffff;
                        end
                        else if (orderSel == 2'b11 || portOf(orderSel, 2'h0) == 2'(i)
                            || portOf(orderSel, 2'h1) == 2'(i))
                        begin
                            portRes_reg[i] <= stage_reg[i];
                        end
                    end
                    state_reg <= rtdseq_pkg::ST_IDLE;
                end
                rtdseq_pkg::ST_CARM:
                begin
                    calCnt_reg <= calCnt_reg + 24'h1;
                    if (setTimeout)
                    begin
                        state_reg <= rtdseq_pkg::ST_CDONE;
                    end
                    else if (slowRise)
                    begin
                        state_reg <= rtdseq_pkg::ST_CMEAS;
                    end
                end
                rtdseq_pkg::ST_CMEAS:
                begin
                    calCnt_reg <= calCnt_reg + 24'h1;
                    calAcc_reg <= calAcc_reg + 32'(`RTDSEQ_TICK_FRAC);
                    if (setTimeout)
                    begin
                        state_reg <= rtdseq_pkg::ST_CDONE;
                    end
                    else if (slowRise)
                    begin
                        calEdges_reg <= calEdges_reg + 4'h1;
                        if (divIf.start)
                        begin
                            state_reg <= rtdseq_pkg::ST_CDIV;
                        end
                    end
                end
                rtdseq_pkg::ST_CDIV:
                begin
                    if (divIf.done)
                    begin
                        trim_reg <= divIf.quotient[30:0];
                        state_reg <= rtdseq_pkg::ST_CDONE;
                    end
                end
                rtdseq_pkg::ST_CDONE:
                begin
                    state_reg <= rtdseq_pkg::ST_IDLE;
                end
                default:
                begin
                    state_reg <= rtdseq_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> rtdseq_top_assertions.sv
// Purpose: Port-level checks of rtdseq_top
// Assumes: Zero-wait APB slave, interrupt enable in bit 14 of the control word
// Notes: Enable bit is shadowed here, since the checker sees only the ports
`default_nettype none
module rtdseq_top_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic capChargeOut,
    input wire logic capChargeOe,
    input wire logic emuSelect,
    input wire logic busy,
    input wire logic intN
);
    localparam int CHG = 250;
    logic acc, statAcc, ctrlWr, intEn, portPhase;
    logic [8:0] chg;
    assign acc = psel && penable;
    assign statAcc = acc && paddr == 8'h08;
    assign ctrlWr = acc && pwrite && paddr == 8'h00;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            intEn <= 1'b0;
        else if (ctrlWr)
            intEn <= pwdata[14];
    end
    always_ff @(posedge clk)
    begin
        chg <= (rst_n && capChargeOe) ? chg + 9'h1 : 9'h0;
        portPhase <= rst_n && busy && (portPhase || (capChargeOe && !emuSelect));
    end
    property p_int_hold;
        !intN && !statAcc && !$past(statAcc) && !ctrlWr && !$past(ctrlWr) |=> !intN;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt released early");
    property p_int_off;
        !intEn && !$past(intEn) && !$past(intEn, 2) |-> intN;
    endproperty
    a_int_off: assert property (p_int_off) else $error("interrupt while disabled");
    property p_charge_len;
        $fell(capChargeOe) |-> chg == CHG;
    endproperty
    a_charge_len: assert property (p_charge_len) else $error("charge length wrong");
    property p_charge_drive;
        capChargeOe |-> capChargeOut;
    endproperty
    a_charge_drive: assert property (p_charge_drive) else $error("charge pin low");
    property p_idle_quiet;
        !busy |-> !capChargeOe && !emuSelect;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("activity while idle");
    property p_dummy_first;
        portPhase |-> !emuSelect;
    endproperty
    a_dummy_first: assert property (p_dummy_first) else $error("dummy after port");
    property p_start;
        acc && pwrite && paddr == 8'h04 && pwdata == 32'h3 && !busy |=> busy;
    endproperty
    a_start: assert property (p_start) else $error("command not started");
    property p_unmapped;
        acc && (paddr[1:0] != 2'h0 || paddr > 8'h1c) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    c_done: cover property ($fell(busy));
    c_int: cover property ($fell(intN));
    c_err: cover property (acc && pslverr);
endmodule
bind rtdseq_top rtdseq_top_assertions i_rtdseq_top_assertions (.clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pslverr, .capChargeOut, .capChargeOe, .emuSelect,
    .busy, .intN);
`default_nettype wire

// >>> rtdseq_rc_model.sv
// Purpose: Behavioural RC network and comparator on the four ports
// Assumes: Port mode 0 normal, 1 shorted, 2 open, 3 comparator stuck below
// Notes: Logs each charge start as {emulation, port} for order checks
`default_nettype none
module rtdseq_rc_model #(
    parameter int SHORT_CYC = 100,
    parameter int LONG_CYC = 2100
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic capChargeOe,
    input wire logic emuSelect,
    input wire logic [1:0] portSel,
    input wire logic [7:0] portMode,
    input wire logic logClr,
    output logic compBelow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] dis;
    logic [1:0] mode;
    logic [2:0] seqLog [0:15];
    int seqCnt = 0;
    assign mode = emuSelect ? 2'h0 : portMode[portSel * 2 +: 2];
    // Charged cap sits above threshold; it falls below after the discharge time
    assign compBelow = mode == 2'h3 || (!capChargeOe && mode != 2'h2
        && dis >= 16'(mode == 2'h1 ? SHORT_CYC : LONG_CYC));
    always @(posedge clk)
    begin
        if (!rst_n)
            dis <= 16'hffff;
        else if (capChargeOe)
            dis <= 16'h0;
        else if (dis != 16'hffff)
            dis <= dis + 16'h1;
        if (logClr)
            seqCnt <= 0;
        else if (rst_n && capChargeOe && dis != 16'h0 && seqCnt < 16)
        begin
            seqLog[seqCnt] <= emuSelect ? 3'h4 : {1'b0, portSel};
            seqCnt <= seqCnt + 1;
        end
    end
endmodule
`default_nettype wire

// >>> tb_rtdseq_top.sv
// Purpose: Self-checking bench of rtdseq_top
// Assumes: Short spacing and limit bases keep the run brief
// Notes: Slow clock period is 100 core cycles
`default_nettype none
module tb_rtdseq_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic e;} rtdseq_row_t;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, slowClk = 0, slowRun = 1;
    logic logClr = 0;
    logic pready, pslverr, compBelow, capChargeOut, capChargeOe, emuSelect, busy, intN, err;
    logic [1:0] portSel;
    logic [7:0] paddr = 8'h0, portMode = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] orders [0:3] = '{8'h08, 8'h0d, 8'h04, 8'he4};
    int failures = 0, compares = 0, slowCnt = 0;
    rtdseq_row_t rows [0:11] = '{'{0, 8'h00, 32'h1b8b, 0}, '{0, 8'h04, 32'h0, 0},
        '{0, 8'h08, 32'h0, 0}, '{0, 8'h0c, 32'h0, 0}, '{0, 8'h10, 32'h0, 0},
        '{0, 8'h14, 32'h0, 0}, '{0, 8'h18, 32'h0, 0}, '{0, 8'h1c, 32'h0, 0},
        '{0, 8'h20, 32'h0, 1}, '{0, 8'h02, 32'h0, 1}, '{1, 8'h0c, 32'hffffffff, 0},
        '{0, 8'h0c, 32'h0, 0}};
    rtdseq_top #(.SPACE_BASE_CYC(600), .LIMIT_BASE_CYC(2000)) i_rtdseq_top (.clk, .rst_n,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .compBelow,
        .slowClk, .capChargeOut, .capChargeOe, .emuSelect, .portSel, .busy, .intN);
    rtdseq_rc_model i_rtdseq_rc_model (.clk, .rst_n, .capChargeOe, .emuSelect, .portSel,
        .portMode, .logClr, .compBelow);
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        slowCnt <= (slowCnt == 49) ? 0 : slowCnt + 1;
        if (slowCnt == 49)
            slowClk <= slowRun & ~slowClk;
    end
    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Request held from setup until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20)
        begin
            chk("pready", 32'h1, 32'h0);
            end_of_test();
        end
    endtask
    task automatic run(input logic [31:0] ctrl, input logic [31:0] op);
        int i;
        apb(1'b1, 8'h00, ctrl);
        apb(1'b1, 8'h04, op);
        apb(1'b1, 8'h04, 32'he);
        for (i = 0; i < 40000 && busy !== 1'b0; i++)
            @(posedge clk);
        if (i == 40000)
        begin
            chk("busy", 32'h0, 32'h1);
            end_of_test();
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int r = 0; r < 12; r++)
        begin
            apb(rows[r].w, rows[r].a, rows[r].d);
            if (!rows[r].w && !rows[r].e)
                chk("reset read", rows[r].d, rd);
            chk("slverr", {31'h0, rows[r].e}, {31'h0, err});
        end
        portMode <= 8'h55;
        for (int o = 0; o < 4; o++)
        begin
            logClr <= 1'b1;
            @(posedge clk);
            logClr <= 1'b0;
            run(32'h4000 | 32'((2 * o + 1) << 2) | 32'(o), 32'h3);
            chk("steps", 32'(2 * o + 1 + ((o == 3) ? 8 : 4)), 32'(i_rtdseq_rc_model.seqCnt));
            for (int k = 0; k < i_rtdseq_rc_model.seqCnt; k++)
                chk("step", (k < 2 * o + 1) ? 32'h4 : 32'(orders[o][(k - 2 * o - 1) / 2 * 2 +: 2]),
                    32'(i_rtdseq_rc_model.seqLog[k]));
        end
        for (int p = 0; p < 4; p++)
            rdchk("short port", 8'h0c + 8'(4 * p), 32'h0);
        chk("intN", 32'h0, {31'h0, intN});
        rdchk("stat", 8'h08, 32'h1);
        repeat (2) @(posedge clk);
        chk("intN", 32'h1, {31'h0, intN});
        portMode <= 8'h24;
        run(32'h4043, 32'h3);
        chk("intN", 32'h0, {31'h0, intN});
        rdchk("stat", 8'h08, 32'h5);
        for (int p = 0; p < 4; p++)
        begin
            apb(1'b0, 8'h0c + 8'(4 * p), 32'h0);
            chk("port", (p == 1) ? 32'h0 : (p == 2) ? 32'hffffffff : 32'h1,
                (p == 1 || p == 2) ? rd : 32'(rd != 32'h0 && rd != 32'hffffffff));
        end
        run(32'h5b80, 32'he);
        chk("intN", 32'h0, {31'h0, intN});
        rdchk("stat", 8'h08, 32'h2);
        rdchk("trim", 8'h1c, 32'(100 * ((65536 * 4 + 125) / 250)));
        slowRun <= 1'b0;
        run(32'h1800, 32'he);
        chk("intN", 32'h1, {31'h0, intN});
        rdchk("stat", 8'h08, 32'h6);
        rdchk("trim", 8'h1c, 32'(100 * ((65536 * 4 + 125) / 250)));
        run(32'h4000, 32'he);
        chk("intN", 32'h0, {31'h0, intN});
        rdchk("stat", 8'h08, 32'h2);
        rdchk("trim", 8'h1c, 32'(100 * ((65536 * 4 + 125) / 250)));
        portMode <= 8'hff;
        run(32'h4000, 32'h3);
        for (int p = 0; p < 4; p++)
            rdchk("fault port", 8'h0c + 8'(4 * p), 32'hffffffff);
        end_of_test();
    end
endmodule
`default_nettype wire
